// File: include/rtc_regs.svh
// Purpose: register map, field positions and timing constants of the clock
// Assumes: 125 MHz system clock, 32.768 kHz time base derived from it
// Notes:   definitions only
`ifndef RTC_REGS_SVH
`define RTC_REGS_SVH

// register addresses
`define RTC_ADDR_SEC         4'h0
`define RTC_ADDR_MIN         4'h1
`define RTC_ADDR_HOUR        4'h2
`define RTC_ADDR_CTRL        4'hF

// control/status field positions
`define RTC_BIT_THRESH       7
`define RTC_BIT_LOWSUP       6
`define RTC_BIT_SPARE_A      5
`define RTC_BIT_HALT         4
`define RTC_BIT_SPARE_B      3
`define RTC_BIT_PERIODIC     2
`define RTC_BIT_WALARM       1
`define RTC_BIT_DALARM       0

// writable masks of the time counters
`define RTC_MASK_SEC         8'h7F
`define RTC_MASK_MIN         8'h7F
`define RTC_MASK_HOUR        8'h3F
`define RTC_HOUR_PM_BIT      5

// bcd limits
`define RTC_SEC_LAST         7'h59
`define RTC_MIN_LAST         7'h59
`define RTC_H24_LAST         6'h23
`define RTC_H12_TWELVE       5'h12
`define RTC_H12_ELEVEN       5'h11
`define RTC_H12_ONE          5'h01
`define RTC_BCD_NINE         4'h9

// timing
`define RTC_CLK_HZ           125000000
`define RTC_CLK_PERIOD_NS    8
`define RTC_XTAL_HZ          32768
`define RTC_XTAL_DIV         (`RTC_CLK_HZ / `RTC_XTAL_HZ)
`define RTC_SUBSEC_LAST      15'h7FFF
`define RTC_SUBSEC_HALF_BIT  14
`define RTC_ALARM_DELAY_US   61
`define RTC_ALARM_DELAY_CYC  (`RTC_ALARM_DELAY_US * 1000 / `RTC_CLK_PERIOD_NS)

// reset values
`define RTC_RST_BYTE         8'h00
`define RTC_RST_HALT         1'b1

`endif

// File: include/rtc_pkg.sv
// Purpose: shared types of the clock block
// Assumes: nothing
// Notes:   constants live in rtc_regs.svh
package rtc_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {
    per_second,
    per_minute,
    per_hour,
    per_month
  } period_e;
endpackage

// File: include/alarm_link.sv
// Purpose: carrier between the clock core and its alarm flag unit
// Assumes: one clock domain
// Notes:   index 1 is the weekly alarm, index 0 the daily alarm
`timescale 1ns/1ps
interface alarm_link;
  logic [1:0] match;
  logic [1:0] enable;
  logic [1:0] clear_req;
  logic       halt_clear;
  logic [1:0] flag;
  modport unit (
    input  match,
    input  enable,
    input  clear_req,
    input  halt_clear,
    output flag
  );
  modport core (
    output match,
    output enable,
    output clear_req,
    output halt_clear,
    input  flag
  );
endinterface

// File: logic/alarm_flags.sv
// Purpose: two alarm flags, each set a fixed delay after a time match
// Assumes: match pulses come from compare logic on the same clock
// Notes:   a new match while a delay runs restarts that delay
`timescale 1ns/1ps
`include "rtc_regs.svh"
module alarm_flags #(
  parameter int DELAY_CYCLES = `RTC_ALARM_DELAY_CYC
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // core side
  alarm_link.unit   link
);

  ////////////////////////////////////////////////////////////////////////////
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      logic [12:0] wait_cnt;
      logic        waiting;
      logic        fire;

      assign fire = waiting && (wait_cnt == 13'(DELAY_CYCLES - 1));

      // delay from match to flag
      always_ff @(posedge clock) begin
        if (rst || link.halt_clear || !link.enable[ch]) begin
          waiting  <= 1'b0;
          wait_cnt <= 13'h0000;
        end else if (link.match[ch]) begin
          waiting  <= 1'b1;
          wait_cnt <= 13'h0000;
        end else if (fire) begin
          waiting  <= 1'b0;
        end else if (waiting) begin
          wait_cnt <= wait_cnt + 13'h0001;
        end
      end

      // a set in the cycle of a clear still lands
      always_ff @(posedge clock) begin
        if (rst || link.halt_clear) begin
          link.flag[ch] <= 1'b0;
        end else if (!link.enable[ch]) begin
          link.flag[ch] <= 1'b0;
        end else if (fire) begin
          link.flag[ch] <= 1'b1;
        end else if (link.clear_req[ch]) begin
          link.flag[ch] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule

// File: logic/rtc_core.sv
// Purpose: status/control register and second, minute, hour counters
// Assumes: register port driven by a serial protocol engine on clock
// Notes:   time base is a 32.768 kHz enable divided from the system clock
//
// Summary of operation
// - control/status register at address Fh
// - threshold bit selects 2.1 or 1.6 volts
// - low supply flag latches, monitor then stops
// - writing 0 clears low supply, restarts monitor
// - spare bits read/write, cleared on halt
// - halt flag sets on oscillator stop, sticks
// - halt clears control bits, releases interrupts
// - writing 0 clears halt flag, rearms sensing
// - after halt, status reads only halt set
// - periodic flag mirrors active low output A
// - level mode: writing 0 releases output A
// - alarm flag sets 61 us after match
// - writing 0 releases alarm output until next
// - alarm flag reads 0 when disabled
// - seconds count bcd 00..59, carry minutes
// - minutes count bcd 00..59, carry hours
// - hours carry to day counters at rollover
// - seconds write resets subsecond divider
// - seconds at 0h, bit 7 reads 0
// - minutes at 1h, bit 7 reads 0
// - hours at 2h, bits 7..6 read 0
// - periodic level output per selected period
`timescale 1ns/1ps
`include "rtc_regs.svh"
module rtc_core #(
  parameter int ALARM_DELAY_CYCLES = `RTC_ALARM_DELAY_CYC
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // register port
  input  wire logic [3:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output      logic [7:0] reg_rdata,
  // analog sense pins, asynchronous
  input  wire logic       osc_halt_in,
  input  wire logic       supply_below_hi,
  input  wire logic       supply_below_lo,
  // settings and events from neighbouring registers
  input  wire logic       hour_mode_24,
  input  wire logic       periodic_pulse_mode,
  input  wire logic [1:0] periodic_period,
  input  wire logic       month_tick,
  input  wire logic       weekly_alarm_enable,
  input  wire logic       daily_alarm_enable,
  input  wire logic       weekly_match,
  input  wire logic       daily_match,
  // outputs
  output      logic       irq_out_a_n,
  output      logic       irq_out_b_n,
  output      logic       day_carry,
  output      logic       halt_clear
);

  ////////////////////////////////////////////////////////////////////////////
  // bcd helpers

  function automatic logic [6:0] bcd_inc(input logic [6:0] v);
    if (v[3:0] == `RTC_BCD_NINE)
      bcd_inc = {3'(v[6:4] + 3'h1), 4'h0};
    else
      bcd_inc = {v[6:4], 4'(v[3:0] + 4'h1)};
  endfunction

  function automatic logic [5:0] hour_inc(input logic [5:0] h,
                                          input logic       mode24);
    logic [4:0] low;
    logic       pm;
    low = h[4:0];
    pm  = h[`RTC_HOUR_PM_BIT];
    if (mode24) begin
      if (h == `RTC_H24_LAST)
        hour_inc = 6'h00;
      else
        hour_inc = 6'(bcd_inc({1'b0, h}));
    end else if (low == `RTC_H12_TWELVE) begin
      hour_inc = {pm, `RTC_H12_ONE};
    end else if (low == `RTC_H12_ELEVEN) begin
      hour_inc = {~pm, `RTC_H12_TWELVE};
    end else begin
      hour_inc = {pm, 5'(bcd_inc({2'b00, low}))};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [2:0]  sync_a;
  logic [2:0]  sync_b;
  logic        halt_s;
  logic        below_hi_s;
  logic        below_lo_s;
  logic [11:0] xtal_cnt;
  logic        tick32;
  logic [14:0] subsec;
  logic        sec_tick;
  logic        sec_carry;
  logic        min_carry;
  logic        hour_carry;
  logic [6:0]  seconds_count;
  logic [6:0]  minutes_count;
  logic [5:0]  hours_count;
  logic        threshold_select;
  logic        low_supply_flag;
  logic        spare_bit_a;
  logic        spare_bit_b;
  logic        osc_halt_flag;
  logic        periodic_flag;
  logic        periodic_event;
  logic        below_sel;
  logic        wr_sec;
  logic        wr_min;
  logic        wr_hour;
  logic        wr_ctl;
  logic [7:0]  status_byte;
  rtc_pkg::period_e period;

  alarm_link alarm ();

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers, first stage read only by the second

  always_ff @(posedge clock) begin
    if (rst) begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
    end else begin
      sync_a <= {osc_halt_in, supply_below_hi, supply_below_lo};
      sync_b <= sync_a;
    end
  end

  assign halt_s     = sync_b[2];
  assign below_hi_s = sync_b[1];
  assign below_lo_s = sync_b[0];

  ////////////////////////////////////////////////////////////////////////////
  // register port decode, unused write bits are masked below

  assign wr_sec  = reg_wr && (reg_addr == `RTC_ADDR_SEC);
  assign wr_min  = reg_wr && (reg_addr == `RTC_ADDR_MIN);
  assign wr_hour = reg_wr && (reg_addr == `RTC_ADDR_HOUR);
  assign wr_ctl  = reg_wr && (reg_addr == `RTC_ADDR_CTRL);

  ////////////////////////////////////////////////////////////////////////////
  // time base: 32.768 kHz enable, then the subsecond divider

  always_ff @(posedge clock) begin
    if (rst || tick32) begin
      xtal_cnt <= 12'h000;
    end else begin
      xtal_cnt <= xtal_cnt + 12'h001;
    end
  end

  assign tick32 = (xtal_cnt == 12'(`RTC_XTAL_DIV - 1));

  // a seconds write restarts the full second from here
  always_ff @(posedge clock) begin
    if (rst || wr_sec) begin
      subsec <= 15'h0000;
    end else if (tick32) begin
      subsec <= subsec + 15'h0001;
    end
  end

  assign sec_tick   = tick32 && (subsec == `RTC_SUBSEC_LAST);
  assign sec_carry  = sec_tick && (seconds_count == `RTC_SEC_LAST);
  assign min_carry  = sec_carry && (minutes_count == `RTC_MIN_LAST);
  assign hour_carry = min_carry && (hour_mode_24 ?
                      (hours_count == `RTC_H24_LAST) :
                      (hours_count == {1'b1, `RTC_H12_ELEVEN}));

  ////////////////////////////////////////////////////////////////////////////
  // time counters; a write in the tick cycle wins over the count

  always_ff @(posedge clock) begin
    if (rst) begin
      seconds_count <= 7'h00;
    end else if (wr_sec) begin
      seconds_count <= 7'(reg_wdata & `RTC_MASK_SEC);
    end else if (sec_carry) begin
      seconds_count <= 7'h00;
    end else if (sec_tick) begin
      seconds_count <= bcd_inc(seconds_count);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      minutes_count <= 7'h00;
    end else if (wr_min) begin
      minutes_count <= 7'(reg_wdata & `RTC_MASK_MIN);
    end else if (min_carry) begin
      minutes_count <= 7'h00;
    end else if (sec_carry) begin
      minutes_count <= bcd_inc(minutes_count);
    end
  end

  // a value that does not exist is the host's problem, no repair here
  always_ff @(posedge clock) begin
    if (rst) begin
      hours_count <= 6'h00;
    end else if (wr_hour) begin
      hours_count <= 6'(reg_wdata & `RTC_MASK_HOUR);
    end else if (min_carry) begin
      hours_count <= hour_inc(hours_count, hour_mode_24);
    end
  end

  // one pulse to both day-of-month and day-of-week counters
  always_ff @(posedge clock) begin
    if (rst) begin
      day_carry <= 1'b0;
    end else begin
      day_carry <= hour_carry;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // oscillation halt sensing

  // while the oscillator is stopped the flag is held; a clear loses
  always_ff @(posedge clock) begin
    if (rst) begin
      osc_halt_flag <= `RTC_RST_HALT;
    end else if (halt_s) begin
      osc_halt_flag <= 1'b1;
    end else if (wr_ctl && !reg_wdata[`RTC_BIT_HALT]) begin
      osc_halt_flag <= 1'b0;
    end
  end

  // tells the adjustment and first control register to clear
  always_ff @(posedge clock) begin
    if (rst) begin
      halt_clear <= 1'b1;
    end else begin
      halt_clear <= halt_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // supply monitor

  assign below_sel = threshold_select ? below_lo_s : below_hi_s;

  always_ff @(posedge clock) begin
    if (rst || halt_s) begin
      threshold_select <= 1'b0;
    end else if (wr_ctl) begin
      threshold_select <= reg_wdata[`RTC_BIT_THRESH];
    end
  end

  // once set the monitor is off, so only the write or a halt can release it
  always_ff @(posedge clock) begin
    if (rst || halt_s) begin
      low_supply_flag <= 1'b0;
    end else if (!low_supply_flag && below_sel) begin
      low_supply_flag <= 1'b1;
    end else if (wr_ctl && !reg_wdata[`RTC_BIT_LOWSUP]) begin
      low_supply_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // spare storage

  always_ff @(posedge clock) begin
    if (rst || halt_s) begin
      spare_bit_a <= 1'b0;
      spare_bit_b <= 1'b0;
    end else if (wr_ctl) begin
      spare_bit_a <= reg_wdata[`RTC_BIT_SPARE_A];
      spare_bit_b <= reg_wdata[`RTC_BIT_SPARE_B];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // periodic interrupt

  assign period = rtc_pkg::period_e'(periodic_period);

  always_comb begin
    case (period)
      rtc_pkg::per_second: periodic_event = sec_tick;
      rtc_pkg::per_minute: periodic_event = sec_carry;
      rtc_pkg::per_hour:   periodic_event = min_carry;
      rtc_pkg::per_month:  periodic_event = month_tick;
      default:             periodic_event = 1'b0;
    endcase
  end

  // pulse mode: low for the first half second after each increment;
  // only the 1 Hz pulse is produced here, the 2 Hz one is not
  always_ff @(posedge clock) begin
    if (rst || halt_s) begin
      periodic_flag <= 1'b0;
    end else if (periodic_pulse_mode) begin
      periodic_flag <= !subsec[`RTC_SUBSEC_HALF_BIT];
    end else if (periodic_event) begin
      periodic_flag <= 1'b1;
    end else if (wr_ctl && !reg_wdata[`RTC_BIT_PERIODIC]) begin
      periodic_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // alarm flags

  assign alarm.match      = {weekly_match, daily_match};
  assign alarm.enable     = {weekly_alarm_enable, daily_alarm_enable};
  assign alarm.clear_req  = {wr_ctl && !reg_wdata[`RTC_BIT_WALARM],
                             wr_ctl && !reg_wdata[`RTC_BIT_DALARM]};
  assign alarm.halt_clear = halt_s;

  alarm_flags #(
    .DELAY_CYCLES (ALARM_DELAY_CYCLES)
  ) u_alarm (
    .clock (clock),
    .rst   (rst),
    .link  (alarm)
  );

  ////////////////////////////////////////////////////////////////////////////
  // interrupt pins, one cycle behind the flags they mirror

  always_ff @(posedge clock) begin
    if (rst) begin
      irq_out_a_n <= 1'b1;
      irq_out_b_n <= 1'b1;
    end else begin
      irq_out_a_n <= !(periodic_flag || alarm.flag[1]);
      irq_out_b_n <= !alarm.flag[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read back; all cleared bits read 0 while the oscillator is stopped

  assign status_byte = {threshold_select, low_supply_flag, spare_bit_a,
                        osc_halt_flag, spare_bit_b, periodic_flag,
                        alarm.flag[1], alarm.flag[0]};

  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata <= `RTC_RST_BYTE;
    end else if (reg_rd) begin
      case (reg_addr)
        `RTC_ADDR_SEC:  reg_rdata <= {1'b0, seconds_count};
        `RTC_ADDR_MIN:  reg_rdata <= {1'b0, minutes_count};
        `RTC_ADDR_HOUR: reg_rdata <= {2'b00, hours_count};
        `RTC_ADDR_CTRL: reg_rdata <= status_byte;
        default:        reg_rdata <= `RTC_RST_BYTE;
      endcase
    end
  end

endmodule

// File: verif/host_model.sv
// Purpose: host side of the register port, drives reads and writes
// Assumes: inputs change at the falling edge, one access at a time
// Notes:   idle address and data show the inverse of the last value
`timescale 1ns/1ps
module host_model (
  // clock
  input  wire logic       clock,
  // register port
  output      logic [3:0] reg_addr,
  output      logic       reg_wr,
  output      logic       reg_rd,
  output      logic [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr  = 4'h0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 8'h00;
  end
  // time values written by the bench are real once their unused bits are masked
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clock);
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask
  // data is valid one edge after the strobe and held until the next read
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clock);
    d        = reg_rdata;
    reg_rd   = 1'b0;
    reg_addr = ~a;
  endtask
endmodule

// File: verif/rtc_monitor.sv
// Purpose: port checker of the clock core
// Assumes: alarm delay in the bench is short, halt pin held for long spans
// Notes:   halt sensing lags the pin by a two-flop synchroniser
`timescale 1ns/1ps
module rtc_monitor #(
  parameter int ALARM_DELAY_CYCLES = 4
) (
  // clock and reset
  input wire logic       clock,
  input wire logic       rst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // events
  input wire logic       osc_halt_in,
  input wire logic       weekly_alarm_enable,
  input wire logic       daily_alarm_enable,
  input wire logic       daily_match,
  // outputs
  input wire logic       irq_out_a_n,
  input wire logic       irq_out_b_n,
  input wire logic       halt_clear
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////
  a_unmapped_zero:
  assert property (reg_rd && reg_addr > 4'h2 && reg_addr < 4'hF
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_sec_min_top:
  assert property (reg_rd && reg_addr <= 4'h1 |=> reg_rdata[7] == 1'b0)
    else $error("seconds or minutes bit 7 set");
  a_hour_top:
  assert property (reg_rd && reg_addr == 4'h2 |=> reg_rdata[7:6] == 2'b00)
    else $error("hours bits 7..6 set");
  a_alarm_not_early:
  assert property (daily_match && irq_out_b_n |=> irq_out_b_n [*4])
    else $error("alarm output fell too early");
  a_alarm_sets_late:
  assert property (daily_match && daily_alarm_enable && !osc_halt_in ##1
    (daily_alarm_enable && !osc_halt_in && !reg_wr) [*6] |-> !irq_out_b_n)
    else $error("alarm output missing after delay");
  a_halt_irq_off:
  assert property (osc_halt_in [*6] |-> irq_out_a_n && irq_out_b_n)
    else $error("interrupt active during halt");
  a_halt_clear_on:
  assert property (osc_halt_in [*5] |-> halt_clear)
    else $error("clear order missing during halt");
  a_halt_status_read:
  assert property (osc_halt_in [*6] ##0 (reg_rd && reg_addr == 4'hF)
    |=> reg_rdata == 8'h10) else $error("status during halt wrong");
  a_flag_pin_a:
  assert property (reg_rd && reg_addr == 4'hF && !reg_wr && !osc_halt_in
    && $stable(weekly_alarm_enable)
    |=> (reg_rdata[2] | reg_rdata[1]) == !irq_out_a_n)
    else $error("output a disagrees with flags");
  a_flag_pin_b:
  assert property (reg_rd && reg_addr == 4'hF && !reg_wr && !osc_halt_in
    && $stable(daily_alarm_enable) |=> reg_rdata[0] == !irq_out_b_n)
    else $error("output b disagrees with flag");
endmodule

// File: verif/tb_top.sv
// Purpose: self-checking bench of the clock core
// Assumes: counts too long to simulate are checked by neither bench nor checker
// Notes:   alarm delay shortened to 4 cycles
`timescale 1ns/1ps
module tb_top;
  localparam int DLY = 4;
  logic       clock, rst, osc_halt_in, supply_below_hi, supply_below_lo;
  logic       hour_mode_24, weekly_alarm_enable, daily_alarm_enable;
  logic       weekly_match, daily_match, irq_out_a_n, irq_out_b_n;
  logic       reg_wr, reg_rd, day_carry, halt_clear;
  logic       periodic_pulse_mode, month_tick;
  logic [1:0] periodic_period;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rd_val;
  int         n_errors, samples_checked;
  host_model host (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  rtc_core #(.ALARM_DELAY_CYCLES(DLY)) dut (.clock(clock), .rst(rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .osc_halt_in(osc_halt_in), .supply_below_hi(supply_below_hi),
    .supply_below_lo(supply_below_lo), .hour_mode_24(hour_mode_24),
    .periodic_pulse_mode(periodic_pulse_mode),
    .periodic_period(periodic_period), .month_tick(month_tick),
    .weekly_alarm_enable(weekly_alarm_enable),
    .daily_alarm_enable(daily_alarm_enable), .weekly_match(weekly_match),
    .daily_match(daily_match), .irq_out_a_n(irq_out_a_n),
    .irq_out_b_n(irq_out_b_n), .day_carry(day_carry),
    .halt_clear(halt_clear));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
    host.rd(a, rd_val);
    check(rd_val, exp);
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clock);
  endtask
  // match pulse, then the output halfway through the delay and after it
  task automatic alarm_run(input logic wk, input logic [7:0] exp);
    if (wk) weekly_match = 1'b1;
    else daily_match = 1'b1;
    @(negedge clock);
    weekly_match = 1'b0;
    daily_match  = 1'b0;
    wait_n(2);
    check({7'h00, wk ? irq_out_a_n : irq_out_b_n}, 8'h01);
    wait_n(4);
    check({7'h00, wk ? irq_out_a_n : irq_out_b_n}, exp);
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // generous: the sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    $display("watchdog expired");
    end_of_test();
  end
  initial begin
    n_errors = 0;
    samples_checked = 0;
    rst = 1'b1;
    osc_halt_in = 1'b0;
    supply_below_hi = 1'b0;
    supply_below_lo = 1'b0;
    hour_mode_24 = 1'b1;
    weekly_alarm_enable = 1'b0;
    daily_alarm_enable = 1'b0;
    weekly_match = 1'b0;
    daily_match = 1'b0;
    periodic_pulse_mode = 1'b0;
    periodic_period = 2'b00;
    month_tick = 1'b0;
    // two cycles: the synchronisers are cleared by reset as well
    wait_n(2);
    rst = 1'b0;
    rchk(4'hF, 8'h10);
    rchk(4'h5, 8'h00);
    host.wr(4'hF, 8'hFF);
    rchk(4'hF, 8'hB8);
    host.wr(4'hF, 8'h2F);
    rchk(4'hF, 8'h28);
    // supply monitor at both trip levels
    host.wr(4'hF, 8'h80);
    supply_below_hi = 1'b1;
    wait_n(4);
    rchk(4'hF, 8'h80);
    supply_below_lo = 1'b1;
    wait_n(4);
    rchk(4'hF, 8'hC0);
    supply_below_lo = 1'b0;
    supply_below_hi = 1'b0;
    wait_n(4);
    rchk(4'hF, 8'hC0);
    host.wr(4'hF, 8'hC0);
    rchk(4'hF, 8'hC0);
    host.wr(4'hF, 8'h80);
    rchk(4'hF, 8'h80);
    host.wr(4'hF, 8'h00);
    supply_below_hi = 1'b1;
    wait_n(4);
    rchk(4'hF, 8'h40);
    supply_below_hi = 1'b0;
    host.wr(4'hF, 8'h00);
    rchk(4'hF, 8'h00);
    // weekly alarm on output a
    weekly_alarm_enable = 1'b1;
    alarm_run(1'b1, 8'h00);
    rchk(4'hF, 8'h02);
    host.wr(4'hF, 8'h03);
    rchk(4'hF, 8'h02);
    host.wr(4'hF, 8'h00);
    rchk(4'hF, 8'h00);
    check({7'h00, irq_out_a_n}, 8'h01);
    // daily alarm on output b, then disabled
    daily_alarm_enable = 1'b1;
    alarm_run(1'b0, 8'h00);
    rchk(4'hF, 8'h01);
    daily_alarm_enable = 1'b0;
    wait_n(2);
    rchk(4'hF, 8'h00);
    check({7'h00, irq_out_b_n}, 8'h01);
    alarm_run(1'b0, 8'h01);
    // periodic flag from the month event, level then pulse mode
    periodic_period = 2'b11;
    month_tick = 1'b1;
    wait_n(1);
    month_tick = 1'b0;
    wait_n(1);
    check({7'h00, irq_out_a_n}, 8'h00);
    rchk(4'hF, 8'h04);
    host.wr(4'hF, 8'h04);
    rchk(4'hF, 8'h04);
    periodic_pulse_mode = 1'b1;
    host.wr(4'hF, 8'h00);
    rchk(4'hF, 8'h04);
    periodic_pulse_mode = 1'b0;
    host.wr(4'hF, 8'h00);
    rchk(4'hF, 8'h00);
    check({7'h00, irq_out_a_n}, 8'h01);
    // time counters and their unused bits
    host.wr(4'h0, 8'hD9);
    rchk(4'h0, 8'h59);
    host.wr(4'h1, 8'hB7);
    rchk(4'h1, 8'h37);
    host.wr(4'h2, 8'hE3);
    rchk(4'h2, 8'h23);
    hour_mode_24 = 1'b0;
    host.wr(4'h2, 8'hF2);
    rchk(4'h2, 8'h32);
    rchk(4'hF, 8'h00);
    check({7'h00, day_carry}, 8'h00);
    // oscillator halt with pending alarm and spare bits set
    host.wr(4'hF, 8'hA8);
    daily_alarm_enable = 1'b1;
    alarm_run(1'b0, 8'h00);
    osc_halt_in = 1'b1;
    wait_n(8);
    check({6'h00, irq_out_a_n, irq_out_b_n}, 8'h03);
    check({7'h00, halt_clear}, 8'h01);
    rchk(4'hF, 8'h10);
    osc_halt_in = 1'b0;
    wait_n(6);
    rchk(4'hF, 8'h10);
    check({7'h00, halt_clear}, 8'h00);
    host.wr(4'hF, 8'h00);
    rchk(4'hF, 8'h00);
    end_of_test();
  end
endmodule
bind rtc_core rtc_monitor #(.ALARM_DELAY_CYCLES(ALARM_DELAY_CYCLES)) mon (
  .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .osc_halt_in(osc_halt_in),
  .weekly_alarm_enable(weekly_alarm_enable),
  .daily_alarm_enable(daily_alarm_enable), .daily_match(daily_match),
  .irq_out_a_n(irq_out_a_n), .irq_out_b_n(irq_out_b_n),
  .halt_clear(halt_clear));
